// ==== hw/eeprom_pkg.sv ====
// constants shared by the data eeprom programmer modules
package eeprom_pkg;
  // ==================================================================
  // bus map, byte addresses on a 10-bit Avalon address
  localparam int          ADDR_W        = 10;
  localparam int          DATA_W        = 32;
  localparam logic [9:0]  CSR_ADDR      = 10'h030;
  localparam int          EE_SEL_BIT    = 9;     // 0x200..0x3FC is the array window
  localparam int          IDX_LSB       = 2;     // one byte per 32-bit word
  // ==================================================================
  // array geometry
  localparam int          EE_BYTES      = 128;
  localparam int          IDX_W         = 7;
  localparam int          ROW_BYTES     = 32;
  localparam int          COL_W         = 5;
  localparam int          ROW_W         = 2;
  localparam logic [4:0]  LAST_COL      = 5'h1F;
  localparam logic [6:0]  LAST_IDX      = 7'h7F;
  localparam logic [7:0]  ERASED_BYTE   = 8'hFF;
  // ==================================================================
  // control/status field layout and reset value
  localparam int          LAT_BIT       = 1;
  localparam int          PGM_BIT       = 0;
  localparam logic [7:0]  CSR_RESET     = 8'h00;
  // ==================================================================
  // default programming time in system clocks
  localparam int          PROG_CYCLES_DEF = 2000;
  // engine states
  typedef enum logic [1:0] {st_idle, st_timing, st_commit, st_erase} engine_state_t;
endpackage

// ==== hw/latch_if.sv ====
// carrier between the controller and its row latch bank
`timescale 1ns/1ps
interface latch_if;
  import eeprom_pkg::*;
  logic             wr;
  logic [COL_W-1:0] wr_col;
  logic [7:0]       wr_data;
  logic             clear;
  logic [COL_W-1:0] rd_col;
  logic [7:0]       rd_data;
  logic             rd_valid;
  modport ctrl (output wr, wr_col, wr_data, clear, rd_col, input rd_data, rd_valid);
  modport bank (input wr, wr_col, wr_data, clear, rd_col, output rd_data, rd_valid);
endinterface

// ==== hw/eeprom_array.sv ====
// byte array memory with one write port and a registered read port
`timescale 1ns/1ps
module eeprom_array #(
  parameter int DEPTH = 128,
  parameter int AW    = 7
) (
  // clock
  input  wire logic          clock,
  // write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  // read port
  input  wire logic [AW-1:0] raddr,
  output      logic [7:0]    q
);
  logic [7:0] cells [DEPTH];

  // cells hold no reset: the array is nonvolatile in intent
  always_ff @(posedge clock) begin
    if (we) begin
      cells[waddr] <= wdata;
    end
  end

  // read data always registered
  always_ff @(posedge clock) begin
    q <= cells[raddr];
  end
endmodule

// ==== hw/row_latch_bank.sv ====
// 32 write latches of one row, with wired-and overwrite
`timescale 1ns/1ps
module row_latch_bank
  import eeprom_pkg::*;
(
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // controller side
  latch_if.bank     lif
);
  logic [7:0]           data  [ROW_BYTES];
  logic [ROW_BYTES-1:0] valid;

  // one latch per column; a second write ANDs into the first
  for (genvar i = 0; i < ROW_BYTES; i++) begin : g_latch
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        data[i]  <= 8'hFF;
        valid[i] <= 1'b0;
      end else if (lif.clear) begin
        data[i]  <= 8'hFF;
        valid[i] <= 1'b0;
      end else if (lif.wr && lif.wr_col == COL_W'(i)) begin
        data[i]  <= data[i] & lif.wr_data;
        valid[i] <= 1'b1;
      end
    end
  end

  // only the commit walk reads the latches, never the bus
  assign lif.rd_data  = data[lif.rd_col];
  assign lif.rd_valid = valid[lif.rd_col];
endmodule

// ==== hw/data_eeprom_page_programmer.sv ====
// data eeprom controller: avalon slave, row latches, timed programming
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// - read mode returns array like rom
// - write mode captures bus writes into latches
// - program bit commits latches to last row
// - completion clears program and latch bits together
// - latches clear at end, lat fall; AND
// - latched data never readable
// - array read in write mode undriven; here it returns zero
// - array write in read mode ignored
// - reset aborts cycle, row undefined
// - wait entered when idle, else after cycle
// - halt stops at once, abandons cycle
// - protection blocks external read and rewrite
// - protection removal erases whole memory first
// - csr resets zero, bits 7:2 zero
// - latch bit cleared only when idle
// - program bit set starts, reads busy
// - cycle length timed internally
module data_eeprom_page_programmer
  import eeprom_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYCLES_DEF
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst_n,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [DATA_W-1:0] writedata,
  output      logic [DATA_W-1:0] readdata,
  output      logic              waitrequest,
  // access origin and protection option
  input  wire logic              ext_access,
  input  wire logic              read_protect,
  input  wire logic              protect_removed,
  // power modes
  input  wire logic              wait_req,
  input  wire logic              halt_req,
  // status
  output      logic              ee_waiting,
  output      logic              ee_halted,
  output      logic              erase_program_memory
);
  // ==================================================================
  // internal signals
  latch_if lif ();
  engine_state_t             state;
  logic                      lat;
  logic                      pgm;
  logic                      lat_prev;
  logic                      phase;
  logic                      ack;
  logic [ROW_W-1:0]          row;
  logic [COL_W-1:0]          col;
  logic [IDX_W-1:0]          erase_idx;
  logic [31:0]               tcount;
  logic                      hit_csr;
  logic                      hit_ee;
  logic                      take;
  logic                      done;
  logic                      start;
  logic                      blocked;
  logic                      mem_we;
  logic [IDX_W-1:0]          mem_waddr;
  logic [7:0]                mem_wdata;
  logic [7:0]                mem_q;
  logic [IDX_W-1:0]          bus_idx;

  // ==================================================================
  // address decode
  function automatic logic is_ee(input logic [ADDR_W-1:0] a);
    return a[EE_SEL_BIT] && a[1:0] == 2'h0;
  endfunction

  assign hit_csr = address == CSR_ADDR;
  assign hit_ee  = is_ee(address);
  assign bus_idx = address[IDX_LSB +: IDX_W];
  // protected parts refuse external reads and rewrites
  assign blocked = read_protect && ext_access;
  // the access takes effect at the edge that samples waitrequest low;
  // acting one edge earlier would let a write land before the master
  // sees its answer
  assign take    = !waitrequest && (read || write);

  // ==================================================================
  // avalon handshake: fixed two-cycle answer, ack blocks a re-take
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase       <= 1'b0;
      ack         <= 1'b0;
      waitrequest <= 1'b1;
    end else begin
      phase       <= (read || write) && !phase && !ack;
      ack         <= phase;
      waitrequest <= !phase;
    end
  end

  // read data, registered; array data needs the registered mem port
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      readdata <= '0;
    end else if (phase && read) begin
      if (hit_csr) begin
        readdata <= {30'h0, lat, pgm};
      end else if (hit_ee && !lat && !blocked) begin
        readdata <= {24'h0, mem_q};
      end else begin
        readdata <= '0;  // write mode, protected and unmapped reads return zero
      end
    end
  end

  // ==================================================================
  // control/status register; hardware clear first so a set wins
  assign done  = state == st_commit && col == LAST_COL;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lat <= CSR_RESET[LAT_BIT];
      pgm <= CSR_RESET[PGM_BIT];
    end else begin
      if (done) begin
        lat <= 1'b0;
        pgm <= 1'b0;
      end
      if (halt_req && state != st_erase) begin
        pgm <= 1'b0;  // halt abandons the cycle
      end
      if (take && write && hit_csr && !blocked) begin
        if (writedata[LAT_BIT]) begin
          lat <= 1'b1;
        end else if (!pgm) begin
          lat <= 1'b0;
        end
        // clearing mid-cycle aborts; data of that row is undefined
        pgm <= writedata[PGM_BIT];
      end
    end
  end

  // previous latch mode, for the falling edge that empties the latches
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lat_prev <= 1'b0;
    end else begin
      lat_prev <= lat;
    end
  end

  // ==================================================================
  // latch capture and row tracking
  assign lif.wr      = take && write && hit_ee && lat && !pgm && !blocked;
  assign lif.wr_col  = bus_idx[COL_W-1:0];
  assign lif.wr_data = writedata[7:0];
  assign lif.clear   = done || (lat_prev && !lat);
  assign lif.rd_col  = col;

  // the row of the last latched write is the one programmed
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      row <= '0;
    end else if (lif.wr) begin
      row <= bus_idx[IDX_W-1 -: ROW_W];
    end
  end

  row_latch_bank u_latches (
    .clock (clock),
    .rst_n (rst_n),
    .lif   (lif.bank)
  );

  // ==================================================================
  // programming engine; async reset aborts a running cycle
  assign start = state == st_idle && pgm && !halt_req;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= st_idle;
    end else begin
      case (state)
        st_idle: begin
          if (protect_removed && !halt_req) begin
            state <= st_erase;
          end else if (start) begin
            state <= st_timing;
          end
        end
        st_timing: begin
          if (halt_req || !pgm) begin
            state <= st_idle;
          end else if (tcount == 32'(PROG_CYCLES - 1)) begin
            state <= st_commit;
          end
        end
        st_commit: begin
          if (halt_req || !pgm || done) begin
            state <= st_idle;
          end
        end
        st_erase: begin
          if (erase_idx == LAST_IDX) begin
            state <= st_idle;
          end
        end
        default: state <= st_idle;
      endcase
    end
  end

  // cycle timer, no software involvement in its length
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tcount <= '0;
    end else if (state == st_timing) begin
      tcount <= tcount + 32'h1;
    end else begin
      tcount <= '0;
    end
  end

  // commit walk over the 32 columns, one byte per clock
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      col <= '0;
    end else if (state == st_commit) begin
      col <= col + 5'h1;
    end else begin
      col <= '0;
    end
  end

  // erase walk over the whole array
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      erase_idx <= '0;
    end else if (state == st_erase) begin
      erase_idx <= erase_idx + 7'h1;
    end else begin
      erase_idx <= '0;
    end
  end

  // one-cycle request that clears program memory with the array
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      erase_program_memory <= 1'b0;
    end else begin
      erase_program_memory <= state == st_idle && protect_removed && !halt_req;
    end
  end

  // ==================================================================
  // array write port: erase or commit of latched bytes only
  always_comb begin
    mem_we    = 1'b0;
    mem_waddr = {row, col};
    mem_wdata = lif.rd_data;
    if (state == st_erase) begin
      mem_we    = 1'b1;
      mem_waddr = erase_idx;
      mem_wdata = ERASED_BYTE;
    end else if (state == st_commit && pgm && !halt_req) begin
      mem_we    = lif.rd_valid;  // untouched columns keep their data
    end
  end

  eeprom_array #(
    .DEPTH (EE_BYTES),
    .AW    (IDX_W)
  ) u_array (
    .clock (clock),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .raddr (bus_idx),
    .q     (mem_q)
  );

  // ==================================================================
  // power mode status: wait only once no cycle runs
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ee_waiting <= 1'b0;
      ee_halted  <= 1'b0;
    end else begin
      ee_waiting <= wait_req && state == st_idle && !start;
      ee_halted  <= halt_req;
    end
  end

  // ==================================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_csr_reserved_zero: assert property (phase && read && hit_csr |=> readdata[31:2] == '0)
    else $error("csr reserved bits not zero");
  a_done_clears_both: assert property (done && !(take && write && hit_csr) |=> !lat && !pgm)
    else $error("completion did not clear both bits");
  a_lat_held_busy: assert property (pgm && lat && !done |=> lat)
    else $error("latch bit dropped while programming");
  a_read_undriven: assert property (phase && read && hit_ee && lat |=> readdata == '0)
    else $error("array read in write mode returned data");
  a_readmode_no_latch: assert property (!lat |-> !lif.wr)
    else $error("latch captured in read mode");
  a_start_timing: assert property (start && !protect_removed |=> state == st_timing)
    else $error("programming did not start");
  a_timer_expiry: assert property (state == st_timing && pgm && !halt_req
                                   && tcount == 32'(PROG_CYCLES - 1) |=> state == st_commit)
    else $error("cycle length wrong");
  a_commit_span: assert property ($rose(state == st_commit) && pgm && !halt_req
                                  ##0 (pgm && !halt_req)[*8] |-> state == st_commit)
    else $error("commit walk cut short");
  a_halt_stops: assert property (halt_req && state != st_erase |=> state == st_idle)
    else $error("halt did not stop engine");
  a_wait_idle: assert property (state != st_idle |=> !ee_waiting)
    else $error("wait entered during a cycle");
  a_protect_read: assert property (phase && read && hit_ee && blocked |=> readdata == '0)
    else $error("protected array read out");
  a_erase_start: assert property (state == st_idle && protect_removed && !halt_req
                                  |=> state == st_erase ##0 erase_program_memory)
    else $error("protection removal did not erase");
  a_answer_time: assert property ((read || write) && !phase && !ack |=> ##1 !waitrequest)
    else $error("slave answer late");
  // writes land only in the answer cycle; latches empty after a cycle
  a_write_on_ready: assert property (lif.wr |-> !waitrequest)
    else $error("latch written outside the answer cycle");
  a_latch_emptied: assert property (done |=> !lif.rd_valid)
    else $error("latches not emptied after the cycle");

  c_program_row: cover property (state == st_commit ##1 state == st_idle);
  c_wait_after: cover property (wait_req && state == st_commit ##[1:40] ee_waiting);
  c_and_overwrite: cover property (lif.wr ##[1:8] lif.wr);
  c_erase_all: cover property (state == st_erase && erase_idx == LAST_IDX);
  c_halt_mid: cover property (state == st_timing && halt_req);
endmodule

// ==== tb/cpu_bus_model.sv ====
// cpu-side avalon master model facing the eeprom controller
`timescale 1ns/1ps
module cpu_bus_model
  import eeprom_pkg::*;
(
  // clock
  input  wire logic              clock,
  // avalon master side
  output      logic [ADDR_W-1:0] address,
  output      logic              read,
  output      logic              write,
  output      logic [DATA_W-1:0] writedata,
  input  wire logic [DATA_W-1:0] readdata,
  input  wire logic              waitrequest
);
  int lapses = 0;

  // idle bus at time zero
  initial begin
    address   = '0;
    read      = 1'b0;
    write     = 1'b0;
    writedata = '0;
  end

  // ==================================================================
  // one access, held until waitrequest is sampled low
  task automatic access(input logic rnw, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
    int n;
    n = 0;
    @(posedge clock);
    address   <= a;
    writedata <= d;
    read      <= rnw;
    write     <= !rnw;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0);
    // the slave answers at the third edge after the request is raised
    if (n != 3) lapses++;
    q = readdata;
    read      <= 1'b0;
    write     <= 1'b0;
    // released lines flip so a stale value is never mistaken for data
    address   <= ~a;
    writedata <= ~d;
  endtask
endmodule

// ==== tb/testbench.sv ====
// self-checking bench for the data eeprom page programmer
`timescale 1ns/1ps
module testbench;
  import eeprom_pkg::*;
  localparam int PROG = 20;
  logic              clock = 1'b0;
  logic              rst_n = 1'b0;
  logic              ext_access = 1'b0;
  logic              read_protect = 1'b0;
  logic              protect_removed = 1'b0;
  logic              wait_req = 1'b0;
  logic              halt_req = 1'b0;
  logic [ADDR_W-1:0] address;
  logic              read;
  logic              write;
  logic [DATA_W-1:0] writedata;
  logic [DATA_W-1:0] readdata;
  logic              waitrequest;
  logic              ee_waiting;
  logic              ee_halted;
  logic              erase_program_memory;
  logic [DATA_W-1:0] q;
  int                errors = 0;
  int                comparisons = 0;
  int                erase_seen = 0;

  // 100 MHz clock
  always #5 clock = ~clock;

  // count erase request pulses
  always @(posedge clock) begin
    if (erase_program_memory === 1'b1) erase_seen++;
  end

  data_eeprom_page_programmer #(.PROG_CYCLES(PROG)) data_eeprom_page_programmer_i (
    .clock(clock), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .ext_access(ext_access), .read_protect(read_protect),
    .protect_removed(protect_removed), .wait_req(wait_req), .halt_req(halt_req),
    .ee_waiting(ee_waiting), .ee_halted(ee_halted),
    .erase_program_memory(erase_program_memory));

  cpu_bus_model cpu_bus_model_i (
    .clock(clock), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));

  // ==================================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    cpu_bus_model_i.access(1'b0, a, d, q);
  endtask

  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    cpu_bus_model_i.access(1'b1, a, '0, q);
    chk(q, exp);
  endtask

  function automatic logic [ADDR_W-1:0] ee(input int i);
    return 10'h200 + 10'(4 * i);
  endfunction

  function automatic logic [31:0] pat(input int i);
    return {24'h0, 8'(i * 7 + 3)};
  endfunction

  // poll the program bit until it falls, bounded
  task automatic wait_done;
    int n;
    n = 0;
    do begin
      cpu_bus_model_i.access(1'b1, CSR_ADDR, '0, q);
      n++;
    end while (q[0] !== 1'b0 && n < 60);
    chk({31'h0, q[0]}, 32'h0);
  endtask

  task automatic final_report;
    if (errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ==================================================================
  // main sequence
  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rchk(CSR_ADDR, 32'h0);
    rchk(10'h034, 32'h0);
    wait_req <= 1'b1;
    repeat (3) @(posedge clock);
    chk({31'h0, ee_waiting}, 32'h1);
    wait_req <= 1'b0;
    repeat (2) @(posedge clock);
    // fill row 1, column 0 written twice to see the and
    wr(CSR_ADDR, 32'hFE);
    rchk(CSR_ADDR, 32'h2);
    rchk(ee(40), 32'h0);
    wr(ee(32), 32'hF0);
    for (int i = 32; i < 64; i++) wr(ee(i), pat(i));
    wr(CSR_ADDR, 32'h3);
    rchk(CSR_ADDR, 32'h3);
    wr(CSR_ADDR, 32'h1);
    rchk(CSR_ADDR, 32'h3);
    wait_done;
    chk(q, 32'h0);
    rchk(ee(32), 32'hE0);
    for (int i = 33; i < 64; i++) rchk(ee(i), pat(i));
    wr(ee(33), 32'h0);
    rchk(ee(33), pat(33));
    // latch dropped by lat fall, wait held off by a running cycle
    wr(CSR_ADDR, 32'h2);
    wr(ee(34), 32'h0);
    wr(CSR_ADDR, 32'h0);
    wr(CSR_ADDR, 32'h2);
    wr(ee(35), 32'h11);
    wr(CSR_ADDR, 32'h3);
    wait_req <= 1'b1;
    repeat (3) @(posedge clock);
    chk({31'h0, ee_waiting}, 32'h0);
    wait_done;
    repeat (3) @(posedge clock);
    chk({31'h0, ee_waiting}, 32'h1);
    wait_req <= 1'b0;
    rchk(ee(34), pat(34));
    rchk(ee(35), 32'h11);
    // halt in mid cycle
    wr(CSR_ADDR, 32'h2);
    wr(ee(64), 32'h55);
    wr(CSR_ADDR, 32'h3);
    repeat (5) @(posedge clock);
    halt_req <= 1'b1;
    repeat (3) @(posedge clock);
    chk({31'h0, ee_halted}, 32'h1);
    halt_req <= 1'b0;
    repeat (2) @(posedge clock);
    rchk(CSR_ADDR, 32'h2);
    // reset in mid cycle
    wr(CSR_ADDR, 32'h3);
    repeat (5) @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rchk(CSR_ADDR, 32'h0);
    // protection gates external access only
    read_protect <= 1'b1;
    ext_access   <= 1'b1;
    rchk(ee(33), 32'h0);
    wr(CSR_ADDR, 32'h2);
    rchk(CSR_ADDR, 32'h0);
    ext_access <= 1'b0;
    rchk(ee(33), pat(33));
    // removing protection erases everything
    protect_removed <= 1'b1;
    read_protect    <= 1'b0;
    @(posedge clock);
    protect_removed <= 1'b0;
    repeat (140) @(posedge clock);
    chk(32'(erase_seen), 32'h1);
    rchk(ee(0), 32'hFF);
    rchk(ee(33), 32'hFF);
    rchk(ee(127), 32'hFF);
    chk(32'(cpu_bus_model_i.lapses), 32'h0);
    final_report;
  end

  // watchdog, far beyond the well under a thousand cycles the tests need
  initial begin
    #100us;
    errors++;
    final_report;
  end
endmodule
